// file: src/plsic_cfg.svh
`ifndef PLSIC_CFG_SVH
`define PLSIC_CFG_SVH

// Register addresses on the management bus.
`define PLSIC_ADDR_INDSEL 5'h14
`define PLSIC_ADDR_ERRCNT 5'h15
`define PLSIC_ADDR_IRQCTL 5'h16
`define PLSIC_ADDR_FLAGS 5'h17

// Reset values.
`define PLSIC_INDSEL_RESET 16'h3fe9
`define PLSIC_ERRCNT_RESET 16'h0000
`define PLSIC_IRQCTL_RESET 16'h0000

// Field positions.
`define PLSIC_FIRST_SRC 5:3
`define PLSIC_SECOND_SRC 2:0
`define PLSIC_IRQ_OE_BIT 15
`define PLSIC_READ_CLR_BIT 14
`define PLSIC_POLARITY_BIT 13
`define PLSIC_AUTO_CLR_BIT 12
`define PLSIC_RESETUP_BIT 11
`define PLSIC_FLAG_COUNT 11

// Indicator source codes.
`define PLSIC_SRC_LINK 3'h0
`define PLSIC_SRC_ACT 3'h1
`define PLSIC_SRC_TX 3'h2
`define PLSIC_SRC_RX 3'h3
`define PLSIC_SRC_COL 3'h4
`define PLSIC_SRC_SPEED 3'h5
`define PLSIC_SRC_DUPLEX 3'h6
`define PLSIC_SRC_ALT 3'h7

// Management frame layout and bit counts.
`define PLSIC_PREAMBLE_BITS 6'h20
`define PLSIC_HEADER_LAST 4'hd
`define PLSIC_DATA_LAST 4'hf
`define PLSIC_HDR_ST 13:12
`define PLSIC_HDR_OP 11:10
`define PLSIC_HDR_PHY 9:5
`define PLSIC_HDR_REG 4:0
`define PLSIC_START_CODE 2'h1
`define PLSIC_OP_READ 2'h2
`define PLSIC_OP_WRITE 2'h1

`endif

// file: src/plsic_pkg.sv
package plsic_pkg;

    typedef enum logic [1:0] {
        MDIO_PREAMBLE = 2'h0,
        MDIO_HEADER = 2'h1,
        MDIO_TURN = 2'h3,
        MDIO_DATA = 2'h2
    } plsic_mdio_e;

    typedef logic [15:0] plsic_word_t;

endpackage

// file: src/plsic_flag_cell.sv
`timescale 1ns/1ps
module plsic_flag_cell (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cond,
    input wire logic readClear,
    input wire logic writeOne,
    input wire logic autoClear,
    input wire logic resetup,
    output logic flag
);
    import plsic_pkg::*;

    logic condPrev;
    logic next_condPrev;
    logic next_flag;
    logic condRise;

    // A flag records the onset of its condition, so a cleared flag is not re-raised
    // by a condition that merely persists.
    always_comb begin
        condRise = cond & ~condPrev;
        next_condPrev = cond;
        next_flag = flag;
        if (readClear) begin
            next_flag = 1'b0;
        end
        if (autoClear && !cond) begin
            next_flag = 1'b0;
        end
        if (writeOne && !(resetup && cond)) begin
            next_flag = 1'b0;
        end
        // A new event in the clearing cycle wins over every clear.
        if (condRise) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            condPrev <= 1'b0;
            flag <= 1'b0;
        end else begin
            condPrev <= next_condPrev;
            flag <= next_flag;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    chk_read_clears: assert property (
        (readClear && !condRise) |=> !flag)
        else $error("Flag survived a clearing read.");

    chk_auto_clear: assert property (
        (autoClear && !cond) |=> !flag)
        else $error("Flag not auto cleared after condition left.");

    chk_sticky_hold: assert property (
        (flag && !autoClear && !readClear && !writeOne) |=> flag)
        else $error("Flag dropped without a clearing cause.");

    chk_write_clears: assert property (
        (writeOne && !resetup && !condRise) |=> !flag)
        else $error("Write of one did not clear flag.");

    chk_resetup_keep: assert property (
        (writeOne && resetup && cond && flag && !readClear && !autoClear) |=> flag)
        else $error("Flag cleared while condition present and resetup set.");

    chk_set_wins: assert property (
        condRise |=> flag)
        else $error("Event lost in the cycle of a clear.");

endmodule

// file: src/plsic_top.sv
// Contract
// - First indicator source select, reset speed.
// - Second indicator select, code seven link.
// - Sixteen-bit readable writable receive error counter.
// - Interrupt pin output enable and polarity.
// - Flag read clears when read-clear enabled.
// - Auto clear when condition goes away.
// - Write one clears when resetup off.
// - Resetup keeps flag while condition present.
// - Enables for wake, power-down, autoneg.
// - Flag register holds eleven write-one-to-clear flags.
// - Low byte enables gate link events.
`timescale 1ns/1ps
`include "plsic_cfg.svh"
module plsic_top #(
    parameter logic [4:0] PHY_ADDR = 5'h01
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic mdc,
    input wire logic mdioIn,
    output logic mdioOut,
    output logic mdioOe,
    input wire logic linkIntegrity,
    input wire logic linkStatus,
    input wire logic activity,
    input wire logic txActive,
    input wire logic rxActive,
    input wire logic collision,
    input wire logic speed100,
    input wire logic fullDuplex,
    input wire logic rxErrPulse,
    input wire logic [`PLSIC_FLAG_COUNT-1:0] eventCond,
    output logic ledFirst,
    output logic ledSecond,
    output logic irqOut,
    output logic irqOe
);
    import plsic_pkg::*;

    localparam int NFLAG = `PLSIC_FLAG_COUNT;

    logic [1:0] mdcSync;
    logic [1:0] next_mdcSync;
    logic [1:0] mdioSync;
    logic [1:0] next_mdioSync;
    logic mdcPrev;
    logic next_mdcPrev;
    logic mdcRise;
    logic mdioBit;
    plsic_mdio_e mdioState;
    plsic_mdio_e next_mdioState;
    logic [5:0] preCnt;
    logic [5:0] next_preCnt;
    logic [3:0] bitCnt;
    logic [3:0] next_bitCnt;
    plsic_word_t shiftReg;
    plsic_word_t next_shiftReg;
    logic isRead;
    logic next_isRead;
    logic isWrite;
    logic next_isWrite;
    logic [4:0] regAddr;
    logic [4:0] next_regAddr;
    logic next_mdioOut;
    logic next_mdioOe;
    logic [13:0] header;
    logic hdrDone;
    logic hdrRead;
    logic addrOk;
    logic writeStb;
    logic readClr;
    plsic_word_t writeData;

    plsic_word_t indSel;
    plsic_word_t next_indSel;
    plsic_word_t errCnt;
    plsic_word_t next_errCnt;
    plsic_word_t irqCtl;
    plsic_word_t next_irqCtl;
    logic [NFLAG-1:0] flags;
    logic [NFLAG-1:0] flagWriteOne;
    logic irqActive;
    logic next_ledFirst;
    logic next_ledSecond;
    logic next_irqOut;
    logic next_irqOe;

    function automatic logic ledPick(input logic [2:0] code, input logic second);
        logic lit;
        unique case (code)
            `PLSIC_SRC_LINK: lit = linkIntegrity;
            `PLSIC_SRC_ACT: lit = activity;
            `PLSIC_SRC_TX: lit = txActive;
            `PLSIC_SRC_RX: lit = rxActive;
            `PLSIC_SRC_COL: lit = collision;
            `PLSIC_SRC_SPEED: lit = speed100;
            `PLSIC_SRC_DUPLEX: lit = fullDuplex;
            `PLSIC_SRC_ALT: lit = second ? linkStatus : 1'b0;
        endcase
        return lit;
    endfunction

    function automatic plsic_word_t regRead(input logic [4:0] addr);
        plsic_word_t value;
        unique case (addr)
            `PLSIC_ADDR_INDSEL: value = indSel;
            `PLSIC_ADDR_ERRCNT: value = errCnt;
            `PLSIC_ADDR_IRQCTL: value = irqCtl;
            `PLSIC_ADDR_FLAGS: value = 16'(flags);
            default: value = 16'h0000;
        endcase
        return value;
    endfunction

    // MDC and MDIO are pins, so both pass two flip-flops before any decode. The data
    // path is delayed exactly as the clock, which keeps the sample point aligned.
    always_comb begin
        next_mdcSync = {mdcSync[0], mdc};
        next_mdioSync = {mdioSync[0], mdioIn};
        next_mdcPrev = mdcSync[1];
        mdcRise = mdcSync[1] & ~mdcPrev;
        mdioBit = mdioSync[1];
        next_mdioState = mdioState;
        next_preCnt = preCnt;
        next_bitCnt = bitCnt;
        next_shiftReg = shiftReg;
        next_isRead = isRead;
        next_isWrite = isWrite;
        next_regAddr = regAddr;
        next_mdioOut = mdioOut;
        next_mdioOe = mdioOe;
        header = {shiftReg[12:0], mdioBit};
        writeData = {shiftReg[14:0], mdioBit};
        addrOk = (header[`PLSIC_HDR_ST] == `PLSIC_START_CODE)
            && (header[`PLSIC_HDR_PHY] == PHY_ADDR);
        hdrDone = 1'b0;
        hdrRead = 1'b0;
        writeStb = 1'b0;
        if (mdcRise) begin
            unique case (mdioState)
                MDIO_PREAMBLE: begin
                    if (mdioBit) begin
                        if (preCnt != `PLSIC_PREAMBLE_BITS) begin
                            next_preCnt = preCnt + 6'h01;
                        end
                    end else if (preCnt == `PLSIC_PREAMBLE_BITS) begin
                        next_mdioState = MDIO_HEADER;
                        next_bitCnt = 4'h1;
                        next_shiftReg = 16'h0000;
                    end else begin
                        next_preCnt = 6'h00;
                    end
                end
                MDIO_HEADER: begin
                    next_shiftReg = writeData;
                    next_bitCnt = bitCnt + 4'h1;
                    if (bitCnt == `PLSIC_HEADER_LAST) begin
                        hdrDone = 1'b1;
                        next_isRead = addrOk && (header[`PLSIC_HDR_OP] == `PLSIC_OP_READ);
                        next_isWrite = addrOk && (header[`PLSIC_HDR_OP] == `PLSIC_OP_WRITE);
                        hdrRead = next_isRead;
                        next_regAddr = header[`PLSIC_HDR_REG];
                        next_bitCnt = 4'h0;
                        next_preCnt = 6'h00;
                        if (next_isRead || next_isWrite) begin
                            next_mdioState = MDIO_TURN;
                        end else begin
                            next_mdioState = MDIO_PREAMBLE;
                        end
                        if (next_isRead) begin
                            next_shiftReg = regRead(header[`PLSIC_HDR_REG]);
                        end
                    end
                end
                MDIO_TURN: begin
                    if (bitCnt == 4'h0) begin
                        next_bitCnt = 4'h1;
                        next_mdioOe = isRead;
                        next_mdioOut = 1'b0;
                    end else begin
                        next_bitCnt = 4'h0;
                        next_mdioState = MDIO_DATA;
                        if (isRead) begin
                            next_mdioOut = shiftReg[15];
                            next_shiftReg = {shiftReg[14:0], 1'b0};
                        end
                    end
                end
                MDIO_DATA: begin
                    next_bitCnt = bitCnt + 4'h1;
                    if (isRead) begin
                        next_mdioOut = shiftReg[15];
                        next_shiftReg = {shiftReg[14:0], 1'b0};
                    end else begin
                        next_shiftReg = writeData;
                    end
                    if (bitCnt == `PLSIC_DATA_LAST) begin
                        next_mdioState = MDIO_PREAMBLE;
                        next_mdioOe = 1'b0;
                        next_mdioOut = 1'b0;
                        writeStb = isWrite;
                    end
                end
            endcase
        end
        readClr = hdrDone && hdrRead && (header[`PLSIC_HDR_REG] == `PLSIC_ADDR_FLAGS)
            && irqCtl[`PLSIC_READ_CLR_BIT];
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // Idle-high reset values keep the release of reset from faking an MDC rise.
            mdcSync <= 2'h3;
            mdioSync <= 2'h3;
            mdcPrev <= 1'b1;
            mdioState <= MDIO_PREAMBLE;
            preCnt <= 6'h00;
            bitCnt <= 4'h0;
            shiftReg <= 16'h0000;
            isRead <= 1'b0;
            isWrite <= 1'b0;
            regAddr <= 5'h00;
            mdioOut <= 1'b0;
            mdioOe <= 1'b0;
        end else begin
            mdcSync <= next_mdcSync;
            mdioSync <= next_mdioSync;
            mdcPrev <= next_mdcPrev;
            mdioState <= next_mdioState;
            preCnt <= next_preCnt;
            bitCnt <= next_bitCnt;
            shiftReg <= next_shiftReg;
            isRead <= next_isRead;
            isWrite <= next_isWrite;
            regAddr <= next_regAddr;
            mdioOut <= next_mdioOut;
            mdioOe <= next_mdioOe;
        end
    end

    // A management write takes precedence over a receive error in the same cycle.
    always_comb begin
        next_indSel = indSel;
        next_irqCtl = irqCtl;
        next_errCnt = errCnt + {15'h0000, rxErrPulse};
        flagWriteOne = '0;
        if (writeStb) begin
            unique case (regAddr)
                `PLSIC_ADDR_INDSEL: next_indSel = writeData;
                `PLSIC_ADDR_ERRCNT: next_errCnt = writeData;
                `PLSIC_ADDR_IRQCTL: next_irqCtl = writeData;
                `PLSIC_ADDR_FLAGS: flagWriteOne = writeData[NFLAG-1:0];
                default: next_indSel = indSel;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            indSel <= `PLSIC_INDSEL_RESET;
            errCnt <= `PLSIC_ERRCNT_RESET;
            irqCtl <= `PLSIC_IRQCTL_RESET;
        end else begin
            indSel <= next_indSel;
            errCnt <= next_errCnt;
            irqCtl <= next_irqCtl;
        end
    end

    for (genvar i = 0; i < NFLAG; i++) begin : gen_flag
        plsic_flag_cell u_cell (
            .sys_clk(sys_clk),
            .rst(rst),
            .cond(eventCond[i]),
            .readClear(readClr),
            .writeOne(flagWriteOne[i]),
            .autoClear(irqCtl[`PLSIC_AUTO_CLR_BIT]),
            .resetup(irqCtl[`PLSIC_RESETUP_BIT]),
            .flag(flags[i])
        );
    end

    always_comb begin
        irqActive = |(flags & irqCtl[NFLAG-1:0]);
        next_irqOut = irqCtl[`PLSIC_POLARITY_BIT] ? irqActive : ~irqActive;
        next_irqOe = irqCtl[`PLSIC_IRQ_OE_BIT];
        next_ledFirst = ledPick(indSel[`PLSIC_FIRST_SRC], 1'b0);
        next_ledSecond = ledPick(indSel[`PLSIC_SECOND_SRC], 1'b1);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irqOut <= 1'b1;
            irqOe <= 1'b0;
            ledFirst <= 1'b0;
            ledSecond <= 1'b0;
        end else begin
            irqOut <= next_irqOut;
            irqOe <= next_irqOe;
            ledFirst <= next_ledFirst;
            ledSecond <= next_ledSecond;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence readTurnStart;
        mdcRise && (mdioState == MDIO_TURN) && isRead && (bitCnt == 4'h0);
    endsequence

    sequence readDataFirst;
        mdcRise && (mdioState == MDIO_TURN) && isRead && (bitCnt == 4'h1);
    endsequence

    chk_first_speed: assert property (
        (indSel[`PLSIC_FIRST_SRC] == `PLSIC_SRC_SPEED) |=> (ledFirst == $past(speed100)))
        else $error("First indicator does not follow speed.");

    chk_second_link: assert property (
        (indSel[`PLSIC_SECOND_SRC] == `PLSIC_SRC_ALT) |=> (ledSecond == $past(linkStatus)))
        else $error("Second indicator does not follow link status.");

    chk_count_readback: assert property (
        (hdrRead && (header[`PLSIC_HDR_REG] == `PLSIC_ADDR_ERRCNT))
            |=> (shiftReg == $past(errCnt)))
        else $error("Counter read returned a wrong value.");

    chk_read_turnaround: assert property (
        readTurnStart ##1 (!mdcRise)[*1] |-> (mdioOe && !mdioOut))
        else $error("Turnaround zero not driven on read.");

    chk_read_first_bit: assert property (
        readDataFirst |=> (mdioOe && (mdioOut == $past(shiftReg[15]))))
        else $error("First data bit not driven after turnaround.");

    chk_irq_polarity: assert property (
        (irqActive && !irqCtl[`PLSIC_POLARITY_BIT]) |=> !irqOut)
        else $error("Active-low interrupt not driven low.");

    chk_irq_enable: assert property (
        $changed(irqCtl[`PLSIC_IRQ_OE_BIT]) |=> (irqOe == $past(irqCtl[`PLSIC_IRQ_OE_BIT])))
        else $error("Interrupt output enable did not follow its bit.");

    chk_read_clear_off: assert property (
        (hdrRead && !irqCtl[`PLSIC_READ_CLR_BIT] && !writeStb && irqCtl[12:11] == 2'h0
            && flags != '0 && eventCond == $past(eventCond)) |=> (flags == $past(flags)))
        else $error("Flags changed by a read with read clear disabled.");

    chk_high_enables: assert property (
        (|(flags[10:8] & irqCtl[10:8])) |=> (irqOut == $past(irqCtl[`PLSIC_POLARITY_BIT])))
        else $error("Enabled power or autoneg flag did not assert pin.");

    chk_flag_readback: assert property (
        (hdrRead && (header[`PLSIC_HDR_REG] == `PLSIC_ADDR_FLAGS))
            |=> (shiftReg == 16'($past(flags))))
        else $error("Flag register read returned a wrong value.");

    chk_low_enables: assert property (
        (|(flags[7:0] & irqCtl[7:0])) |=> (irqOut == $past(irqCtl[`PLSIC_POLARITY_BIT])))
        else $error("Enabled link event flag did not assert pin.");

    chk_irq_idle: assert property (
        !irqActive |=> (irqOut == !$past(irqCtl[`PLSIC_POLARITY_BIT])))
        else $error("Interrupt pin active with no enabled flag.");

    chk_count_step: assert property (
        (rxErrPulse && !writeStb) |=> (errCnt == $past(errCnt) + 16'h0001))
        else $error("Receive error did not advance the counter.");

endmodule

// file: verif/plsic_mgmt_host.sv
`timescale 1ns/1ps
module plsic_mgmt_host (
    input wire logic sys_clk,
    input wire logic mdioOut,
    input wire logic mdioOe,
    output logic mdc,
    output logic mdioIn
);
    import plsic_pkg::*;

    // Management clock half period in sys_clk cycles; the block needs at least 2.
    int halfCycles = 5;
    logic hostOe = 1'b0;
    logic hostBit = 1'b1;

    initial begin
        mdc = 1'b1;
    end

    // The data line has a pull-up, so nobody driving reads as one.
    assign mdioIn = mdioOe ? mdioOut : (hostOe ? hostBit : 1'b1);

    // Data changes while the clock is low and is sampled at its rising edge.
    task automatic bit_cycle(input logic drive, input logic b, output logic got);
        @(posedge sys_clk);
        mdc <= 1'b0;
        hostOe <= drive;
        hostBit <= b;
        repeat (halfCycles) @(posedge sys_clk);
        got = mdioIn;
        mdc <= 1'b1;
        repeat (halfCycles - 1) @(posedge sys_clk);
    endtask

    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] regAddr,
            input plsic_word_t wdata, output plsic_word_t rdata);
        logic [13:0] hdr;
        logic got;
        logic isWrite;
        hdr = {2'b01, op, phy, regAddr};
        isWrite = (op == 2'b01);
        for (int i = 0; i < 32; i++) begin
            bit_cycle(1'b1, 1'b1, got);
        end
        for (int i = 13; i >= 0; i--) begin
            bit_cycle(1'b1, hdr[i], got);
        end
        bit_cycle(isWrite, 1'b1, got);
        bit_cycle(isWrite, 1'b0, got);
        for (int i = 15; i >= 0; i--) begin
            bit_cycle(isWrite, wdata[i], got);
            rdata[i] = got;
        end
        @(posedge sys_clk);
        hostOe <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule

// file: verif/phy_led_select_and_irq_control_test.sv
`timescale 1ns/1ps
`include "plsic_cfg.svh"
module phy_led_select_and_irq_control_test;
    import plsic_pkg::*;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic mdc;
    logic mdioIn;
    logic mdioOut;
    logic mdioOe;
    // Source order: link, activity, tx, rx, collision, speed, duplex, link status.
    logic [7:0] src = 8'h00;
    logic rxErrPulse = 1'b0;
    logic [10:0] eventCond = 11'h000;
    logic ledFirst;
    logic ledSecond;
    logic irqOut;
    logic irqOe;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int seed;
    int n;
    int j;
    plsic_word_t w;

    always #10 sys_clk = ~sys_clk;

    plsic_top #(.PHY_ADDR(5'h01)) u_dut (
        .sys_clk(sys_clk), .rst(rst), .mdc(mdc), .mdioIn(mdioIn), .mdioOut(mdioOut),
        .mdioOe(mdioOe), .linkIntegrity(src[0]), .activity(src[1]), .txActive(src[2]),
        .rxActive(src[3]), .collision(src[4]), .speed100(src[5]), .fullDuplex(src[6]),
        .linkStatus(src[7]), .rxErrPulse(rxErrPulse), .eventCond(eventCond),
        .ledFirst(ledFirst), .ledSecond(ledSecond), .irqOut(irqOut), .irqOe(irqOe)
    );

    plsic_mgmt_host u_host (
        .sys_clk(sys_clk), .mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc), .mdioIn(mdioIn)
    );

    function automatic logic exp_led(input logic [2:0] code, input logic second);
        if (code == 3'h7) begin
            return second ? src[7] : 1'b0;
        end
        return src[code];
    endfunction

    task automatic check(input plsic_word_t seen, input plsic_word_t exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares=%0d num_errors=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic wr(input logic [4:0] a, input plsic_word_t d);
        plsic_word_t unused;
        u_host.frame(`PLSIC_OP_WRITE, 5'h01, a, d, unused);
    endtask

    task automatic rdchk(input logic [4:0] a, input plsic_word_t exp);
        plsic_word_t got;
        u_host.frame(`PLSIC_OP_READ, 5'h01, a, 16'h0000, got);
        check(got, exp);
    endtask

    task automatic set_cond(input int i, input logic v);
        @(posedge sys_clk);
        eventCond[i] <= v;
    endtask

    task automatic pinchk(input logic expOut, input logic expOe);
        repeat (3) @(posedge sys_clk);
        #1;
        check(plsic_word_t'(irqOut), plsic_word_t'(expOut));
        check(plsic_word_t'(irqOe), plsic_word_t'(expOe));
    endtask

    task automatic led_trials(input logic [2:0] first, input logic [2:0] second);
        repeat (4) begin
            @(posedge sys_clk);
            src <= 8'($urandom);
            repeat (2) @(posedge sys_clk);
            #1;
            check(plsic_word_t'(ledFirst), plsic_word_t'(exp_led(first, 1'b0)));
            check(plsic_word_t'(ledSecond), plsic_word_t'(exp_led(second, 1'b1)));
        end
    endtask

    initial begin
        seed = $urandom(2);
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        pinchk(1'b1, 1'b0);
        rdchk(`PLSIC_ADDR_INDSEL, 16'h3fe9);
        rdchk(`PLSIC_ADDR_ERRCNT, 16'h0000);
        rdchk(`PLSIC_ADDR_IRQCTL, 16'h0000);
        led_trials(3'h5, 3'h1);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            u_host.halfCycles = (c % 2 == 1) ? 4 : 7;
            w = {10'($urandom), 3'(c), 3'(7 - c)};
            wr(`PLSIC_ADDR_INDSEL, w);
            rdchk(`PLSIC_ADDR_INDSEL, w);
            led_trials(3'(c), 3'(7 - c));
        end
        u_host.halfCycles = 5;
        $display("test indicators done");
        for (int k = 0; k < 3; k++) begin
            w = (k == 0) ? 16'hffff : 16'($urandom);
            n = 1 + $urandom_range(4);
            wr(`PLSIC_ADDR_ERRCNT, w);
            repeat (n) begin
                @(posedge sys_clk);
                rxErrPulse <= 1'b1;
                @(posedge sys_clk);
                rxErrPulse <= 1'b0;
            end
            rdchk(`PLSIC_ADDR_ERRCNT, w + 16'(n));
        end
        $display("test counter done");
        // Another event's flag sits set but disabled, so only the enable decides the pin.
        for (int i = 6; i < 11; i++) begin
            j = (i == 10) ? 6 : i + 1;
            wr(`PLSIC_ADDR_IRQCTL, 16'ha000 | (16'h0001 << i));
            set_cond(j, 1'b1);
            pinchk(1'b0, 1'b1);
            set_cond(i, 1'b1);
            pinchk(1'b1, 1'b1);
            wr(`PLSIC_ADDR_FLAGS, (16'h0001 << i) | (16'h0001 << j));
            pinchk(1'b0, 1'b1);
            rdchk(`PLSIC_ADDR_FLAGS, 16'h0000);
            @(posedge sys_clk);
            eventCond <= 11'h000;
        end
        $display("test enables done");
        wr(`PLSIC_ADDR_IRQCTL, 16'hc100);
        set_cond(8, 1'b1);
        set_cond(8, 1'b0);
        pinchk(1'b0, 1'b1);
        rdchk(`PLSIC_ADDR_FLAGS, 16'h0100);
        pinchk(1'b1, 1'b1);
        wr(`PLSIC_ADDR_IRQCTL, 16'h8100);
        set_cond(8, 1'b1);
        set_cond(8, 1'b0);
        rdchk(`PLSIC_ADDR_FLAGS, 16'h0100);
        pinchk(1'b0, 1'b1);
        wr(`PLSIC_ADDR_IRQCTL, 16'h9100);
        pinchk(1'b1, 1'b1);
        set_cond(8, 1'b1);
        pinchk(1'b0, 1'b1);
        set_cond(8, 1'b0);
        pinchk(1'b1, 1'b1);
        $display("test clearing done");
        wr(`PLSIC_ADDR_IRQCTL, 16'h8900);
        set_cond(8, 1'b1);
        wr(`PLSIC_ADDR_FLAGS, 16'h0100);
        pinchk(1'b0, 1'b1);
        set_cond(8, 1'b0);
        wr(`PLSIC_ADDR_FLAGS, 16'h0100);
        pinchk(1'b1, 1'b1);
        wr(`PLSIC_ADDR_IRQCTL, 16'h2100);
        pinchk(1'b0, 1'b0);
        $display("test resetup done");
        report_and_stop();
    end
endmodule
